// File: tb/ctrl_model.sv
// behavioural memory controller: command clock, address pins, strobes, termination pin
`timescale 1ns/10ps
`default_nettype none
module ctrl_model (
   output var logic ck,
   output var logic [sdram_train_pkg::CA_W-1:0] ca,
   output var logic [sdram_train_pkg::BYTES-1:0] dqs_t,
   output var logic termination_control,
   input wire logic [sdram_train_pkg::DQ_W-1:0] dq_out
);
   import sdram_train_pkg::*;
   initial begin
      ck = 1'b0;
      ca = '0;
      dqs_t = '0; // strobes parked low before any pulse
      termination_control = 1'b0;
   end
   // one training frame; ck stands low outside it, released pins show the inverse
   task automatic frame(input logic [CA_W-1:0] r, input logic [CA_W-1:0] f);
      #5.3 ca = r;
      #32 ck = 1'b1;
      #16 ca = f;
      #16 ck = 1'b0;
      #32 ca = ~f;
   endtask : frame
   // one ck pulse with a strobe pulse d ns after its rise
   task automatic probe(input int b, input int d);
      #5.3;
      fork
         begin
            ck = 1'b1;
            #32 ck = 1'b0;
         end
         begin
            #(d) dqs_t[b] = 1'b1;
            #16 dqs_t[b] = 1'b0;
         end
      join
      #64;
   endtask : probe
   // shorten the strobe delay until feedback goes low to high, then keep it
   task automatic level(input int b, output int lock);
      logic prev;
      prev = 1'b1;
      lock = -1;
      for (int d = 58; d > 0 && lock < 0; d -= 12) begin
         probe(b, d);
         if (prev === 1'b0 && dq_out[8*b] === 1'b1) lock = d;
         prev = dq_out[8*b];
      end
   endtask : level
endmodule : ctrl_model
`default_nettype wire

// File: tb/sdram_train_monitor.sv
// port checker for the training, leveling and termination block
`timescale 1ns/10ps
`default_nettype none
module sdram_train_monitor (
   input wire logic clk,
   input wire logic resetn,
   input wire sdram_train_pkg::mrw_cmd_t mrw,
   input wire logic read_active,
   input wire logic power_down,
   input wire sdram_train_pkg::term_enable_t term_enable,
   input wire logic [7:0] termination_config,
   input wire sdram_train_pkg::train_state_t train_state,
   input wire logic leveling_active
);
   import sdram_train_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_train_entry: assert property (
      mrw.valid && mrw.addr == ADDR_TRAIN_ENTRY && mrw.op == OP_TRAIN_ENTRY && train_state == TRAIN_OFF
      |=> train_state == TRAIN_FIRST) else $error("entry missed");
   a_train_remap: assert property (
      mrw.valid && mrw.addr == ADDR_TRAIN_REMAP && mrw.op == OP_TRAIN_REMAP && train_state == TRAIN_FIRST
      |=> train_state == TRAIN_ALT) else $error("remap missed");
   a_train_exit: assert property (
      mrw.valid && mrw.addr == ADDR_TRAIN_EXIT && mrw.op == OP_TRAIN_EXIT |=> train_state == TRAIN_OFF)
      else $error("exit missed");
   a_level_bit: assert property (
      mrw.valid && mrw.addr == ADDR_LEVELING |=> leveling_active == $past(mrw.op[LEVEL_EN_BIT]))
      else $error("leveling bit");
   a_config_store: assert property (
      mrw.valid && mrw.addr == ADDR_TERM_CONFIG |=> termination_config == $past(mrw.op))
      else $error("config not stored");
   a_read_off: assert property (read_active |=> term_enable == '0) else $error("on in read");
   a_train_off: assert property (train_state != TRAIN_OFF |=> term_enable == '0) else $error("on in training");
   a_level_dq: assert property (
      leveling_active [*2] |-> !term_enable.dq && !term_enable.dm) else $error("dq on in leveling");
   a_pd_off: assert property (
      (power_down && !termination_config[TERM_PD_BIT]) [*6] |-> term_enable == '0) else $error("on in power down");
   cover property (train_state == TRAIN_ALT);
   cover property (leveling_active && term_enable.dqs);
   cover property (power_down && term_enable.dq);
endmodule : sdram_train_monitor
bind sdram_training_and_termination sdram_train_monitor sdram_train_monitor_inst (.clk, .resetn, .mrw,
   .read_active, .power_down, .term_enable, .termination_config, .train_state, .leveling_active);
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the training and termination block
`timescale 1ns/10ps
`default_nettype none
module tb;
   import sdram_train_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   mrw_cmd_t mrw = '0;
   logic read_active = 1'b0;
   logic power_down = 1'b0;
   logic self_refresh = 1'b0;
   logic ck, termination_control, leveling_active;
   logic [CA_W-1:0] ca, r, f;
   logic [BYTES-1:0] dqs_t;
   logic [DQ_W-1:0] dq_out, dq_oe;
   term_enable_t term_enable;
   logic [1:0] termination_resistance;
   logic [7:0] termination_config, op;
   train_state_t train_state;
   int fail_count = 0;
   int compares = 0;
   int lk;
   typedef struct {int k; logic [31:0] e;} note_t;
   note_t q[$];
   note_t n;
   event sample;
   always #4 clk = ~clk;
   sdram_training_and_termination sdram_training_and_termination_inst (.clk, .resetn, .mrw, .ck, .ca, .dqs_t,
      .termination_control, .read_active, .power_down, .self_refresh, .dq_out, .dq_oe, .term_enable,
      .termination_resistance, .termination_config, .train_state, .leveling_active);
   ctrl_model ctrl_model_inst (.ck, .ca, .dqs_t, .termination_control, .dq_out);
   function automatic logic [31:0] pick(input int k);
      case (k)
         0: pick = dq_out;
         1: pick = 32'(term_enable);
         2: pick = 32'(train_state);
         3: pick = 32'(leveling_active);
         4: pick = 32'(termination_config);
         5: pick = 32'(termination_resistance);
         6: pick = dq_oe;
         16: pick = lk;
         default: pick = k < 12 ? 32'(dq_out[8*(k-8)+:8]) : 32'(dq_oe[8*(k-12)+:8]);
      endcase
   endfunction : pick
   function automatic logic [31:0] map_of(input int m, input logic [CA_W-1:0] r, input logic [CA_W-1:0] f);
      logic [31:0] e;
      e = '0;
      for (int p = 0; p < PAIRS; p++) begin
         if (m == 0) e[2*p+:2] = {f[p<4 ? p : p+1], r[p<4 ? p : p+1]};
      end
      if (m == 1) e[1:0] = {f[4], r[4]};
      if (m == 1) e[9:8] = {f[9], r[9]};
      return e;
   endfunction : map_of
   always @(sample) begin
      while (q.size() > 0) begin
         n = q.pop_front();
         compares++;
         if (pick(n.k) !== n.e) begin
            fail_count++;
            $display("BAD %0t kind %0d got %h want %h", $time, n.k, pick(n.k), n.e);
         end
      end
   end
   task automatic chk(input int k, input logic [31:0] e);
      q.push_back('{k, e});
      ->sample;
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [7:0] o);
      mrw = '{1'b1, a, o};
      cyc(1);
      mrw.valid = 1'b0;
      cyc(1);
   endtask : wr
   task automatic summarize();
      #1;
      if (fail_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : summarize
   initial begin
      #400000;
      fail_count++;
      summarize();
   end
   initial begin
      void'($urandom(32'h4c05));
      cyc(16);
      resetn = 1'b1;
      cyc(1);
      chk(4, 0);
      chk(2, 0);
      ctrl_model_inst.termination_control = 1'b1;
      for (int s = 0; s < 4; s++) begin
         op = {5'($urandom()), 1'b0, 2'(s)};
         wr(ADDR_TERM_CONFIG, op);
         chk(4, op);
         cyc(4);
         chk(5, s);
         chk(1, s ? 7 : 0);
      end
      read_active = 1'b1;
      cyc(2);
      chk(1, 0);
      read_active = 1'b0;
      cyc(2);
      chk(1, 7);
      ctrl_model_inst.termination_control = 1'b0;
      cyc(5);
      chk(1, 0);
      ctrl_model_inst.termination_control = 1'b1;
      for (int p = 0; p < 2; p++) begin
         wr(ADDR_TERM_CONFIG, {5'h0, 1'(p), 2'h1});
         cyc(3);
         power_down = 1'b1;
         cyc(8);
         chk(1, p ? 7 : 0);
         power_down = 1'b0;
         cyc(8);
         chk(1, 7);
      end
      self_refresh = 1'b1;
      cyc(8);
      chk(1, 0);
      self_refresh = 1'b0;
      cyc(8);
      chk(1, 7);
      wr(ADDR_TRAIN_REMAP, OP_TRAIN_REMAP);
      chk(2, 0);
      wr(ADDR_TRAIN_ENTRY, OP_TRAIN_ENTRY ^ 8'h01);
      chk(2, 0);
      wr(ADDR_TRAIN_ENTRY, OP_TRAIN_ENTRY);
      chk(2, 1);
      chk(1, 0);
      for (int m = 0; m < 2; m++) begin
         if (m == 1) wr(ADDR_TRAIN_REMAP, OP_TRAIN_REMAP); // second pass writes the remap first, so it runs in the alternate mapping
         chk(2, m + 1);
         r = CA_W'($urandom());
         f = CA_W'($urandom());
         ctrl_model_inst.frame(r, f);
         cyc(2);
         chk(0, map_of(m, r, f));
         chk(6, 32'hffff_ffff);
      end
      wr(ADDR_TRAIN_EXIT, OP_TRAIN_EXIT); // both mappings done first
      chk(2, 0);
      cyc(2);
      chk(1, 7);
      wr(ADDR_LEVELING, 8'h80); // only leveling writes follow
      chk(3, 1);
      chk(12, 0);
      chk(1, 3'b010);
      for (int b = 0; b < BYTES; b++) begin
         ctrl_model_inst.probe(b, 58);
         cyc(1);
         chk(8 + b, 8'h00);
         ctrl_model_inst.level(b, lk);
         cyc(1);
         chk(8 + b, 8'hff);
         chk(12 + b, 8'hff);
         chk(16, 22);
      end
      ctrl_model_inst.termination_control = 1'b0;
      cyc(5);
      chk(1, 0);
      wr(ADDR_LEVELING, 8'h7f);
      chk(3, 0);
      summarize();
   end
endmodule : tb
`default_nettype wire

// File: verilog/sdram_train_pkg.sv
// constants and types for the training and termination block
package sdram_train_pkg;

   localparam int CA_W = 10;
   localparam int DQ_W = 32;
   localparam int BYTES = 4;
   localparam int PAIRS = 8;

   // mode register addresses and operands that steer this block
   localparam logic [7:0] ADDR_TRAIN_ENTRY = 8'h29;
   localparam logic [7:0] OP_TRAIN_ENTRY = 8'ha4;
   localparam logic [7:0] ADDR_TRAIN_EXIT = 8'h2a;
   localparam logic [7:0] OP_TRAIN_EXIT = 8'ha8;
   localparam logic [7:0] ADDR_TRAIN_REMAP = 8'h30;
   localparam logic [7:0] OP_TRAIN_REMAP = 8'hc0;
   localparam logic [7:0] ADDR_LEVELING = 8'h02;
   localparam logic [7:0] ADDR_TERM_CONFIG = 8'h0b;

   // field positions
   localparam int LEVEL_EN_BIT = 7;
   localparam int TERM_RES_LSB = 0;
   localparam int TERM_RES_MSB = 1;
   localparam int TERM_PD_BIT = 2;

   // values after reset
   localparam logic [7:0] TERM_CONFIG_RESET = 8'h00;
   localparam logic [1:0] TERM_RES_OFF = 2'h0;

   // timing, figures in ns, counts in cycles of clk (longest times round down)
   localparam int CLK_PERIOD_NS = 8;
   localparam int WLO_NS = 20;
   localparam int TERM_DISABLE_NS = 24;
   localparam int TERM_ENABLE_NS = 24;
   localparam int WLO_CYC = (WLO_NS / CLK_PERIOD_NS < 1) ? 1 : WLO_NS / CLK_PERIOD_NS;
   localparam int TERM_DISABLE_CYC = (TERM_DISABLE_NS / CLK_PERIOD_NS < 1) ? 1 : TERM_DISABLE_NS / CLK_PERIOD_NS;
   localparam int TERM_ENABLE_CYC = (TERM_ENABLE_NS / CLK_PERIOD_NS < 1) ? 1 : TERM_ENABLE_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 4;

   // mode register write as handed over by the command decoder
   typedef struct packed {
      logic valid;
      logic [7:0] addr;
      logic [7:0] op;
   } mrw_cmd_t;

   // termination switches per pin group
   typedef struct packed {
      logic dq;
      logic dqs;
      logic dm;
   } term_enable_t;

   typedef enum logic [1:0] {
      TRAIN_OFF = 2'b00,
      TRAIN_FIRST = 2'b01,
      TRAIN_ALT = 2'b10
   } train_state_t;

endpackage : sdram_train_pkg

// File: verilog/sdram_training_and_termination.sv
// command/address training, write leveling and termination control of the memory device
`timescale 1ns/10ps
`default_nettype none

module sdram_training_and_termination (
   input wire logic clk,
   input wire logic resetn,
   input wire sdram_train_pkg::mrw_cmd_t mrw,
   input wire logic ck,
   input wire logic [sdram_train_pkg::CA_W-1:0] ca,
   input wire logic [sdram_train_pkg::BYTES-1:0] dqs_t,
   input wire logic termination_control,
   input wire logic read_active,
   input wire logic power_down,
   input wire logic self_refresh,
   output logic [sdram_train_pkg::DQ_W-1:0] dq_out,
   output logic [sdram_train_pkg::DQ_W-1:0] dq_oe,
   output sdram_train_pkg::term_enable_t term_enable,
   output logic [1:0] termination_resistance,
   output logic [7:0] termination_config,
   output sdram_train_pkg::train_state_t train_state,
   output logic leveling_active
);
   import sdram_train_pkg::*;

   // synchronisers for everything arriving from pins
   logic ck_s1;
   logic ck_s2;
   logic ck_s3;
   logic [CA_W-1:0] ca_s1;
   logic [CA_W-1:0] ca_s2;
   logic [BYTES-1:0] dqs_s1;
   logic [BYTES-1:0] dqs_s2;
   logic [BYTES-1:0] dqs_s3;
   logic term_pin_s1;
   logic term_pin_s2;

   logic [CA_W-1:0] ca_rise;
   logic [CA_W-1:0] ca_fall;
   logic ca_seen;
   logic [BYTES-1:0] lvl_sample;
   logic [BYTES-1:0] lvl_pending;
   logic [BYTES-1:0] lvl_fed;
   logic [BYTES-1:0] lvl_value;
   logic [CNT_W-1:0] lvl_cnt [BYTES];
   logic suppress;
   logic [CNT_W-1:0] sup_cnt;
   logic sup_target;
   logic ck_rise;
   logic ck_fall;
   logic [BYTES-1:0] dqs_rise;
   logic term_base;
   logic [DQ_W-1:0] next_dq;

   // true when a mode register write matches an address and operand
   function automatic logic mrw_hit(input mrw_cmd_t c, input logic [7:0] a, input logic [7:0] o);
      mrw_hit = c.valid && (c.addr == a) && (c.op == o);
   endfunction : mrw_hit

   // command/address index carried by pin pair p in the first mapping
   function automatic int first_map(input int p);
      first_map = (p < 4) ? p : p + 1;
   endfunction : first_map

   // true when a mode register write targets an address, whatever its operand
   function automatic logic mrw_to(input mrw_cmd_t c, input logic [7:0] a);
      mrw_to = c.valid && (c.addr == a);
   endfunction : mrw_to

   // ck and the strobes keep a third stage only to find their edges
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ck_s1 <= 1'b0;
         ck_s2 <= 1'b0;
         ck_s3 <= 1'b0;
      end else begin
         ck_s1 <= ck;
         ck_s2 <= ck_s1;
         ck_s3 <= ck_s2;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ca_s1 <= '0;
         ca_s2 <= '0;
      end else begin
         ca_s1 <= ca;
         ca_s2 <= ca_s1;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         dqs_s1 <= '0;
         dqs_s2 <= '0;
         dqs_s3 <= '0;
      end else begin
         dqs_s1 <= dqs_t;
         dqs_s2 <= dqs_s1;
         dqs_s3 <= dqs_s2;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         term_pin_s1 <= 1'b0;
         term_pin_s2 <= 1'b0;
      end else begin
         term_pin_s1 <= termination_control;
         term_pin_s2 <= term_pin_s1;
      end
   end

   assign ck_rise = ck_s2 && !ck_s3;
   assign ck_fall = !ck_s2 && ck_s3;
   assign dqs_rise = dqs_s2 & ~dqs_s3;

   // training mode: entry, remap and exit decoded from mode register writes
   always_ff @(posedge clk) begin
      if (!resetn) begin
         train_state <= TRAIN_OFF;
      end else begin
         case (train_state)
            TRAIN_OFF: begin
               if (mrw_hit(mrw, ADDR_TRAIN_ENTRY, OP_TRAIN_ENTRY)) begin
                  train_state <= TRAIN_FIRST;
               end
            end
            TRAIN_FIRST: begin
               if (mrw_hit(mrw, ADDR_TRAIN_EXIT, OP_TRAIN_EXIT)) begin
                  train_state <= TRAIN_OFF;
               end else if (mrw_hit(mrw, ADDR_TRAIN_REMAP, OP_TRAIN_REMAP)) begin
                  train_state <= TRAIN_ALT;
               end
            end
            TRAIN_ALT: begin
               if (mrw_hit(mrw, ADDR_TRAIN_EXIT, OP_TRAIN_EXIT)) begin
                  train_state <= TRAIN_OFF;
               end
            end
            default: begin
               train_state <= TRAIN_OFF;
            end
         endcase
      end
   end

   // capture the command/address inputs on each clock edge while training
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ca_rise <= '0;
      end else if (train_state != TRAIN_OFF && ck_rise) begin
         ca_rise <= ca_s2;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ca_fall <= '0;
      end else if (train_state != TRAIN_OFF && ck_fall) begin
         ca_fall <= ca_s2;
      end
   end

   // pins stay released until a falling ck edge has been captured while training
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ca_seen <= 1'b0;
      end else if (train_state == TRAIN_OFF) begin
         ca_seen <= 1'b0;
      end else if (ck_fall) begin
         ca_seen <= 1'b1;
      end
   end

   // write leveling enable and termination configuration registers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         leveling_active <= 1'b0;
      end else if (mrw_to(mrw, ADDR_LEVELING)) begin
         leveling_active <= mrw.op[LEVEL_EN_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         termination_config <= TERM_CONFIG_RESET;
      end else if (mrw_to(mrw, ADDR_TERM_CONFIG)) begin
         termination_config <= mrw.op;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         termination_resistance <= TERM_RES_OFF;
      end else begin
         termination_resistance <= termination_config[TERM_RES_MSB:TERM_RES_LSB];
      end
   end

   // per byte: strobe rise samples the clock level, feedback after the output delay
   always_ff @(posedge clk) begin
      if (!resetn) begin
         lvl_sample <= '0;
         lvl_pending <= '0;
         lvl_fed <= '0;
         lvl_value <= '0;
         for (int b = 0; b < BYTES; b++) begin
            lvl_cnt[b] <= '0;
         end
      end else if (!leveling_active) begin
         lvl_pending <= '0;
         lvl_fed <= '0;
      end else begin
         for (int b = 0; b < BYTES; b++) begin
            if (dqs_rise[b]) begin
               // ck_s2 and dqs_s2 come from one clk sample, so the level matches the strobe edge
               lvl_sample[b] <= ck_s2;
               lvl_pending[b] <= 1'b1;
               lvl_cnt[b] <= CNT_W'(WLO_CYC - 1);
            end else if (lvl_pending[b]) begin
               if (lvl_cnt[b] == '0) begin
                  lvl_value[b] <= lvl_sample[b];
                  lvl_fed[b] <= 1'b1;
                  lvl_pending[b] <= 1'b0;
               end else begin
                  lvl_cnt[b] <= lvl_cnt[b] - 1'b1;
               end
            end
         end
      end
   end

   // data pin contents for training or leveling
   always_comb begin
      next_dq = '0;
      if (train_state == TRAIN_FIRST) begin
         for (int p = 0; p < PAIRS; p++) begin
            next_dq[2*p] = ca_rise[first_map(p)];
            next_dq[2*p+1] = ca_fall[first_map(p)];
         end
      end else if (train_state == TRAIN_ALT) begin
         next_dq[0] = ca_rise[4];
         next_dq[1] = ca_fall[4];
         next_dq[8] = ca_rise[9];
         next_dq[9] = ca_fall[9];
      end else if (leveling_active) begin
         for (int b = 0; b < BYTES; b++) begin
            next_dq[8*b +: 8] = {8{lvl_value[b] & lvl_fed[b]}};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         dq_out <= '0;
      end else begin
         dq_out <= next_dq;
      end
   end

   // enables switch in the same cycle as the values that they release
   always_ff @(posedge clk) begin
      if (!resetn) begin
         dq_oe <= '0;
      end else begin
         if (train_state != TRAIN_OFF) begin
            dq_oe <= {DQ_W{ca_seen}};
         end else if (leveling_active) begin
            for (int b = 0; b < BYTES; b++) begin
               dq_oe[8*b +: 8] <= {8{lvl_fed[b]}};
            end
         end else begin
            dq_oe <= '0;
         end
      end
   end

   // power down without bit 2, or self refresh, gates termination after a window
   // each direction needs a full window of steady request, so a short blip changes nothing
   assign sup_target = self_refresh || (power_down && !termination_config[TERM_PD_BIT]);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         suppress <= 1'b0;
         sup_cnt <= '0;
      end else if (sup_target == suppress) begin
         sup_cnt <= '0;
      end else if (sup_target && sup_cnt == CNT_W'(TERM_DISABLE_CYC - 1)) begin
         suppress <= 1'b1;
         sup_cnt <= '0;
      end else if (!sup_target && sup_cnt == CNT_W'(TERM_ENABLE_CYC - 1)) begin
         suppress <= 1'b0;
         sup_cnt <= '0;
      end else begin
         sup_cnt <= sup_cnt + 1'b1;
      end
   end

   // pin acts on termination unless disabled, reading, training or suppressed
   assign term_base = (termination_config[TERM_RES_MSB:TERM_RES_LSB] != 2'h0)
                      && term_pin_s2
                      && !read_active
                      && (train_state == TRAIN_OFF)
                      && !suppress;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         term_enable <= '0;
      end else begin
         term_enable.dqs <= term_base;
         term_enable.dq <= term_base && !leveling_active;
         term_enable.dm <= term_base && !leveling_active;
      end
   end

endmodule : sdram_training_and_termination

`default_nettype wire
